// ===== hdl/packet_sram_defines.vh
// Purpose: Constants for the packet buffer and its window access
// Assumes: Byte addresses are 15 bits wide
// Notes:   Register select codes are local to this block's host port
`ifndef PACKET_SRAM_DEFINES_VH
`define PACKET_SRAM_DEFINES_VH

`define MEM_LAST_ADDR      15'h5FFF
`define MEM_WORDS          12288
`define RX_START_RESET     15'h5340
`define RX_START_MAX       15'h5FFE

// Host register select codes
`define SEL_RX_START       4'h0
`define SEL_GEN_RD_PTR     4'h1
`define SEL_GEN_WR_PTR     4'h2
`define SEL_RX_RD_PTR      4'h3
`define SEL_RX_WR_PTR      4'h4
`define SEL_UA_RD_PTR      4'h5
`define SEL_UA_WR_PTR      4'h6
`define SEL_UA_START       4'h7
`define SEL_UA_END         4'h8
`define SEL_GEN_WINDOW     4'h9
`define SEL_RX_WINDOW      4'hA
`define SEL_UA_WINDOW      4'hB
`define SEL_DIRECT         4'hC

// Reset values of user area bounds, placed outside memory
`define UA_START_RESET     16'h6000
`define UA_END_RESET       16'h6001

`endif

// ===== hdl/packet_sram_mem.v
// Purpose: 12K x 16 buffer memory with byte-lane writes and registered reads
// Assumes: One write port and one read port per cycle
// Notes:   Read data appear one clock after the address
`timescale 1ns/1ps
module packet_sram_mem #(
    parameter WORDS = 12288,
    parameter AW    = 14
) (
    // Clock
    input  wire          ref_clk,
    // Write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_word,
    input  wire [1:0]    wr_lane,
    input  wire [15:0]   wr_data,
    // Read port
    input  wire [AW-1:0] rd_word,
    output reg  [15:0]   rd_data_r
);
    reg [15:0] mem [0:WORDS-1];

    always @(posedge ref_clk) begin
        if (wr_en && wr_lane[0]) begin
            mem[wr_word][7:0] <= wr_data[7:0];
        end
        if (wr_en && wr_lane[1]) begin
            mem[wr_word][15:8] <= wr_data[15:8];
        end
        rd_data_r <= mem[rd_word];
    end
endmodule

// ===== hdl/packet_sram_window_access.v
// Purpose: Shared packet buffer with a receive ring and three window pointer pairs
// Assumes: Requestors are synchronous to ref_clk; one request per requestor per cycle
// Notes:   Memory is byte addressed; word = addr[14:1], lane = addr[0]
//
// Overview of operation
// - Buffer is 12K words of 16 bits, bytes 0000h to 5FFFh.
// - General area runs from zero to one below receive start.
// - Receive area runs from receive start to last byte inclusive.
// - Receive writes go sequentially and wrap from last byte to start.
// - Receive start bit zero reads zero; writable even values up to 5FFEh while receive is disabled.
// - Receive start resets to 5340h.
// - Host reaches whole buffer while other requestors are active.
// - Receive hardware is always granted memory first.
// - Transmit fetches from any byte address, odd included.
// - Transmit only reads the buffer.
// - Transmit always gets read access to the whole memory.
// - Parallel port reads and writes buffer directly.
// - No direct access when serial host interface is selected.
// - Three pointer pairs: general, receive, user area.
// - Window is 8 bits; only low-byte strobe writes it.
// - Window reads return the byte on the low data lines.
// - Window read uses read pointer; window write uses write pointer.
// - Used pointer advances by one after each window access.
// - General pointers wrap to zero at start minus one or last byte.
// - Receive pointers wrap from last byte to receive start.
// - User pointers go to user start at user end first, else wrap.
// - User start bit zero is zero; user end bit zero is one.
`timescale 1ns/1ps
`include "packet_sram_defines.vh"
module packet_sram_window_access #(
    parameter WORDS = `MEM_WORDS
) (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // Host register port
    input  wire        host_req,
    input  wire        host_wr,
    input  wire [3:0]  host_sel,
    input  wire [14:0] host_addr,
    input  wire [1:0]  host_lane,
    input  wire [15:0] host_wdata,
    input  wire        serial_mode,
    input  wire        receive_enable_bit,
    output reg  [15:0] host_rdata_r,
    output reg         host_ack_r,
    // Receive writer
    input  wire        rx_wr,
    input  wire [7:0]  rx_byte,
    input  wire        rx_restart,
    output reg  [14:0] rx_head_r,
    // Transmit reader
    input  wire        tx_rd,
    input  wire [14:0] tx_addr,
    output reg  [7:0]  tx_byte_r,
    output reg         tx_valid_r,
    // Other requestor (DMA)
    input  wire        dma_req,
    input  wire        dma_wr,
    input  wire [14:0] dma_addr,
    input  wire [7:0]  dma_wdata,
    output reg  [7:0]  dma_rdata_r,
    output reg         dma_ack_r
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_DONE = 3'b100;

    reg  [15:0] rx_start_r;
    reg  [14:0] gen_rd_r, gen_wr_r, rxp_rd_r, rxp_wr_r, ua_rd_r, ua_wr_r;
    reg  [15:0] ua_start_r, ua_end_r;
    reg  [2:0]  st_r;
    reg         hlane_r, tx_lane_r, tx_pend_r, dma_pend_r, dma_lane_r;
    wire [15:0] rd_data;
    wire [14:0] rx_start15 = rx_start_r[14:0];

    // Wrap functions
    function [14:0] gen_next;
        input [14:0] p;
        input [14:0] st;
        begin
            if (p == st - 15'h0001 || p == `MEM_LAST_ADDR) gen_next = 15'h0000;
            else gen_next = p + 15'h0001;
        end
    endfunction

    function [14:0] rx_next;
        input [14:0] p;
        input [14:0] st;
        begin
            if (p == `MEM_LAST_ADDR) rx_next = st;
            else rx_next = p + 15'h0001;
        end
    endfunction

    function [14:0] ua_next;
        input [14:0] p;
        input [15:0] s;
        input [15:0] e;
        begin
            if ({1'b0, p} == e) ua_next = s[14:0];
            else if (p == `MEM_LAST_ADDR) ua_next = 15'h0000;
            else ua_next = p + 15'h0001;
        end
    endfunction

    // Host decode
    wire h_win    = host_sel == `SEL_GEN_WINDOW || host_sel == `SEL_RX_WINDOW ||
                    host_sel == `SEL_UA_WINDOW;
    wire h_direct = host_sel == `SEL_DIRECT && !serial_mode;
    wire h_mem    = h_win || h_direct;
    wire h_go     = host_req && st_r == ST_IDLE && !host_ack_r;
    wire h_wwin   = h_go && host_wr && h_win && host_lane[0];
    reg  [14:0] h_maddr;
    always @* begin
        case (host_sel)
            `SEL_GEN_WINDOW: h_maddr = host_wr ? gen_wr_r : gen_rd_r;
            `SEL_RX_WINDOW:  h_maddr = host_wr ? rxp_wr_r : rxp_rd_r;
            `SEL_UA_WINDOW:  h_maddr = host_wr ? ua_wr_r : ua_rd_r;
            default:         h_maddr = host_addr;
        endcase
    end

    // Arbitration: receive, then host, then DMA on the write port
    wire h_mem_wr = h_go && host_wr && h_mem && (h_direct ? |host_lane : host_lane[0]);
    wire h_wport  = h_mem_wr && !rx_wr;
    wire d_wport  = dma_req && dma_wr && !dma_pend_r && !dma_ack_r && !rx_wr && !h_mem_wr;
    reg         w_en;
    reg  [14:0] w_addr;
    reg  [1:0]  w_lane;
    reg  [15:0] w_data;
    always @* begin
        w_en   = 1'b0;
        w_addr = 15'h0000;
        w_lane = 2'b00;
        w_data = 16'h0000;
        if (rx_wr) begin
            w_en   = 1'b1;
            w_addr = rx_head_r;
            w_lane = rx_head_r[0] ? 2'b10 : 2'b01;
            w_data = {rx_byte, rx_byte};
        end else if (h_wport) begin
            w_en   = 1'b1;
            w_addr = h_maddr;
            if (h_direct) begin
                w_lane = host_lane;
                w_data = host_wdata;
            end else begin
                w_lane = h_maddr[0] ? 2'b10 : 2'b01;
                w_data = {host_wdata[7:0], host_wdata[7:0]};
            end
        end else if (d_wport) begin
            w_en   = 1'b1;
            w_addr = dma_addr;
            w_lane = dma_addr[0] ? 2'b10 : 2'b01;
            w_data = {dma_wdata, dma_wdata};
        end
    end

    // Read port: transmit first, then host, then DMA
    wire h_rd_go = h_go && !host_wr && h_mem;
    wire h_rport = h_rd_go && !tx_rd;
    wire d_rport = dma_req && !dma_wr && !dma_pend_r && !dma_ack_r && !tx_rd && !h_rd_go;
    wire [14:0] r_addr = tx_rd ? tx_addr : (h_rport ? h_maddr : dma_addr);

    packet_sram_mem #(
        .WORDS (WORDS),
        .AW    (14)
    ) u_mem (
        .ref_clk   (ref_clk),
        .wr_en     (w_en),
        .wr_word   (w_addr[14:1]),
        .wr_lane   (w_lane),
        .wr_data   (w_data),
        .rd_word   (r_addr[14:1]),
        .rd_data_r (rd_data)
    );

    wire h_taken = h_rd_go ? h_rport : (h_mem_wr ? h_wport : 1'b1);

    // Host state and registers
    reg [15:0] reg_rd;
    always @* begin
        case (host_sel)
            `SEL_RX_START:   reg_rd = rx_start_r;
            `SEL_GEN_RD_PTR: reg_rd = {1'b0, gen_rd_r};
            `SEL_GEN_WR_PTR: reg_rd = {1'b0, gen_wr_r};
            `SEL_RX_RD_PTR:  reg_rd = {1'b0, rxp_rd_r};
            `SEL_RX_WR_PTR:  reg_rd = {1'b0, rxp_wr_r};
            `SEL_UA_RD_PTR:  reg_rd = {1'b0, ua_rd_r};
            `SEL_UA_WR_PTR:  reg_rd = {1'b0, ua_wr_r};
            `SEL_UA_START:   reg_rd = ua_start_r;
            `SEL_UA_END:     reg_rd = ua_end_r;
            default:         reg_rd = 16'h0000;
        endcase
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_start_r   <= {1'b0, `RX_START_RESET};
            gen_rd_r     <= 15'h0000;
            gen_wr_r     <= 15'h0000;
            rxp_rd_r     <= `RX_START_RESET;
            rxp_wr_r     <= `RX_START_RESET;
            ua_rd_r      <= 15'h0000;
            ua_wr_r      <= 15'h0000;
            ua_start_r   <= `UA_START_RESET;
            ua_end_r     <= `UA_END_RESET;
            st_r         <= ST_IDLE;
            hlane_r      <= 1'b0;
            host_rdata_r <= 16'h0000;
            host_ack_r   <= 1'b0;
        end else begin
            host_ack_r <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    if (h_go && h_taken) begin
                        hlane_r <= h_maddr[0];
                        st_r    <= h_rd_go ? ST_WAIT : ST_DONE;
                        if (!h_rd_go) begin
                            host_rdata_r <= reg_rd;
                        end
                        if (host_wr) begin
                            case (host_sel)
                                `SEL_RX_START: begin
                                    if (!receive_enable_bit &&
                                        host_wdata[14:0] <= `RX_START_MAX) begin
                                        rx_start_r <= {1'b0, host_wdata[14:1], 1'b0};
                                    end
                                end
                                `SEL_GEN_RD_PTR: gen_rd_r <= host_wdata[14:0];
                                `SEL_GEN_WR_PTR: gen_wr_r <= host_wdata[14:0];
                                `SEL_RX_RD_PTR:  rxp_rd_r <= host_wdata[14:0];
                                `SEL_RX_WR_PTR:  rxp_wr_r <= host_wdata[14:0];
                                `SEL_UA_RD_PTR:  ua_rd_r  <= host_wdata[14:0];
                                `SEL_UA_WR_PTR:  ua_wr_r  <= host_wdata[14:0];
                                `SEL_UA_START:   ua_start_r <= {host_wdata[15:1], 1'b0};
                                `SEL_UA_END:     ua_end_r   <= {host_wdata[15:1], 1'b1};
                                default: ;
                            endcase
                        end
                        // Pointer advance after window access
                        if (h_wwin || (h_rd_go && h_win)) begin
                            case (host_sel)
                                `SEL_GEN_WINDOW: begin
                                    if (host_wr) gen_wr_r <= gen_next(gen_wr_r, rx_start15);
                                    else gen_rd_r <= gen_next(gen_rd_r, rx_start15);
                                end
                                `SEL_RX_WINDOW: begin
                                    if (host_wr) rxp_wr_r <= rx_next(rxp_wr_r, rx_start15);
                                    else rxp_rd_r <= rx_next(rxp_rd_r, rx_start15);
                                end
                                default: begin
                                    if (host_wr) ua_wr_r <= ua_next(ua_wr_r, ua_start_r, ua_end_r);
                                    else ua_rd_r <= ua_next(ua_rd_r, ua_start_r, ua_end_r);
                                end
                            endcase
                        end
                    end
                end
                ST_WAIT: begin
                    st_r <= ST_DONE;
                    if (h_direct) begin
                        host_rdata_r <= rd_data;
                    end else begin
                        host_rdata_r <= {8'h00, hlane_r ? rd_data[15:8] : rd_data[7:0]};
                    end
                end
                ST_DONE: begin
                    host_ack_r <= 1'b1;
                    st_r       <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Receive head, transmit and DMA data paths
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_head_r   <= `RX_START_RESET;
            tx_byte_r   <= 8'h00;
            tx_valid_r  <= 1'b0;
            tx_pend_r   <= 1'b0;
            tx_lane_r   <= 1'b0;
            dma_rdata_r <= 8'h00;
            dma_ack_r   <= 1'b0;
            dma_pend_r  <= 1'b0;
            dma_lane_r  <= 1'b0;
        end else begin
            if (rx_restart) begin
                rx_head_r <= rx_start15;
            end else if (rx_wr) begin
                rx_head_r <= rx_next(rx_head_r, rx_start15);
            end
            tx_pend_r  <= tx_rd;
            tx_lane_r  <= tx_addr[0];
            tx_valid_r <= tx_pend_r;
            if (tx_pend_r) begin
                tx_byte_r <= tx_lane_r ? rd_data[15:8] : rd_data[7:0];
            end
            dma_pend_r <= d_rport;
            dma_lane_r <= dma_addr[0];
            dma_ack_r  <= d_wport || dma_pend_r;
            if (dma_pend_r) begin
                dma_rdata_r <= dma_lane_r ? rd_data[15:8] : rd_data[7:0];
            end
        end
    end
endmodule

// ===== tb/sram_checker.sv
// Purpose: Port assertions for the packet buffer block
// Assumes: One clock, reset asynchronous and active low
// Notes:   Bound to the top module below
`timescale 1ns/1ps
`include "packet_sram_defines.vh"
module sram_checker (
    // Clock and reset
    input wire        ref_clk,
    input wire        rstn,
    // Host port
    input wire        host_req,
    input wire        host_wr,
    input wire [3:0]  host_sel,
    input wire        serial_mode,
    input wire [15:0] host_rdata_r,
    input wire        host_ack_r,
    // Requestors
    input wire        rx_wr,
    input wire        rx_restart,
    input wire [14:0] rx_head_r,
    input wire        tx_rd,
    input wire        tx_valid_r,
    input wire        dma_req,
    input wire        dma_ack_r
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire win_rd = host_ack_r && !host_wr && host_sel >= `SEL_GEN_WINDOW
                  && host_sel <= `SEL_UA_WINDOW;
    sequence tx_answer;
        ##[1:3] tx_valid_r;
    endsequence
    ack_pulse_a: assert property (host_ack_r |=> !host_ack_r)
        else $error("host ack longer than one cycle");
    host_served_a: assert property ($rose(host_req) |-> ##[2:40] host_ack_r)
        else $error("host request not answered");
    tx_served_a: assert property (tx_rd |-> tx_answer)
        else $error("transmit read not answered");
    tx_cause_a: assert property (tx_valid_r |-> $past(tx_rd) || $past(tx_rd, 2)
        || $past(tx_rd, 3))
        else $error("transmit valid without request");
    rx_step_a: assert property (rx_wr && !rx_restart && rx_head_r != `MEM_LAST_ADDR
        |=> rx_head_r == $past(rx_head_r) + 15'h1)
        else $error("receive head did not step by one");
    rx_wrap_a: assert property (rx_wr && !rx_restart && rx_head_r == `MEM_LAST_ADDR
        |=> !rx_head_r[0] && rx_head_r <= `RX_START_MAX)
        else $error("receive head wrapped outside area");
    head_range_a: assert property (rx_head_r <= `MEM_LAST_ADDR)
        else $error("receive head beyond memory");
    win_upper_a: assert property (win_rd |-> host_rdata_r[15:8] == 8'h00)
        else $error("window read upper byte not zero");
    serial_block_a: assert property (host_ack_r && !host_wr && serial_mode
        && host_sel == `SEL_DIRECT |-> host_rdata_r == 16'h0000)
        else $error("direct read in serial mode returned data");
    dma_served_a: assert property ($rose(dma_req) |-> ##[1:40] dma_ack_r)
        else $error("dma request not answered");
endmodule
bind packet_sram_window_access sram_checker chk_i (.ref_clk(ref_clk), .rstn(rstn),
    .host_req(host_req), .host_wr(host_wr), .host_sel(host_sel),
    .serial_mode(serial_mode), .host_rdata_r(host_rdata_r), .host_ack_r(host_ack_r),
    .rx_wr(rx_wr), .rx_restart(rx_restart), .rx_head_r(rx_head_r), .tx_rd(tx_rd),
    .tx_valid_r(tx_valid_r), .dma_req(dma_req), .dma_ack_r(dma_ack_r));

// ===== tb/host_model.sv
// Purpose: Host side of the register port
// Assumes: Request held until acknowledge
// Notes:   Released address and write data lines show inverted values
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire        ref_clk,
    // Answer
    input wire [15:0] host_rdata_r,
    input wire        host_ack_r,
    // Request
    output reg        host_req,
    output reg        host_wr,
    output reg [3:0]  host_sel,
    output reg [14:0] host_addr,
    output reg [1:0]  host_lane,
    output reg [15:0] host_wdata
);
    initial {host_req, host_wr, host_sel, host_addr, host_lane, host_wdata} = 0;
    task access(input w, input [3:0] s, input [14:0] a, input [1:0] l, input [15:0] d,
                output [15:0] q, output ok);
        integer i;
        begin
            @(posedge ref_clk);
            #1;
            host_req = 1;
            host_wr = w;
            host_sel = s;
            host_addr = a;
            host_lane = l;
            host_wdata = d;
            ok = 0;
            q = 0;
            for (i = 0; i < 40 && !ok; i = i + 1) begin
                @(posedge ref_clk);
                if (host_ack_r === 1'b1) begin
                    ok = 1;
                    q = host_rdata_r;
                end
            end
            #1;
            host_req = 0;
            host_addr = ~a;
            host_wdata = ~d;
        end
    endtask
endmodule

// ===== tb/testbench.sv
// Purpose: Scenario bench for the packet buffer block
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Host port driven through host_model
`timescale 1ns/1ps
`include "packet_sram_defines.vh"
module testbench;
    reg         ref_clk = 0, rstn = 0, serial_mode = 0, receive_enable_bit = 0;
    reg         rx_wr = 0, rx_restart = 0, tx_rd = 0, dma_req = 0, dma_wr = 0, ok;
    reg  [7:0]  rx_byte = 0, dma_wdata = 0;
    reg  [14:0] tx_addr = 0, dma_addr = 0;
    reg  [15:0] q;
    wire        host_req, host_wr, host_ack_r, tx_valid_r, dma_ack_r;
    wire [3:0]  host_sel;
    wire [14:0] host_addr, rx_head_r;
    wire [1:0]  host_lane;
    wire [15:0] host_wdata, host_rdata_r;
    wire [7:0]  tx_byte_r, dma_rdata_r;
    integer     errors = 0, n_tests = 0, i;
    always #20 ref_clk = ~ref_clk;
    packet_sram_window_access dut (.ref_clk(ref_clk), .rstn(rstn), .host_req(host_req),
        .host_wr(host_wr), .host_sel(host_sel), .host_addr(host_addr),
        .host_lane(host_lane), .host_wdata(host_wdata), .serial_mode(serial_mode),
        .receive_enable_bit(receive_enable_bit), .host_rdata_r(host_rdata_r),
        .host_ack_r(host_ack_r), .rx_wr(rx_wr), .rx_byte(rx_byte),
        .rx_restart(rx_restart), .rx_head_r(rx_head_r), .tx_rd(tx_rd), .tx_addr(tx_addr),
        .tx_byte_r(tx_byte_r), .tx_valid_r(tx_valid_r), .dma_req(dma_req),
        .dma_wr(dma_wr), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
        .dma_rdata_r(dma_rdata_r), .dma_ack_r(dma_ack_r));
    host_model host (.ref_clk(ref_clk), .host_rdata_r(host_rdata_r),
        .host_ack_r(host_ack_r), .host_req(host_req), .host_wr(host_wr),
        .host_sel(host_sel), .host_addr(host_addr), .host_lane(host_lane),
        .host_wdata(host_wdata));
    task chk(input [8*10:1] name, input [15:0] seen, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("wrong value %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", n_tests, errors);
            if (errors == 0 && n_tests > 0) $display("No errors found");
            else $display("Errors were found");
            $finish;
        end
    endtask
    task hx(input w, input [3:0] s, input [14:0] a, input [1:0] l, input [15:0] d);
        begin
            host.access(w, s, a, l, d, q, ok);
            if (ok !== 1'b1) begin
                errors = errors + 1;
                results;
            end
        end
    endtask
    task tx_chk(input [14:0] a, input [7:0] exp);
        integer k;
        begin
            @(posedge ref_clk) #1 tx_rd = 1;
            tx_addr = a;
            @(posedge ref_clk) #1 tx_rd = 0;
            tx_addr = ~a;
            for (k = 0; k < 4 && tx_valid_r !== 1'b1; k = k + 1) @(posedge ref_clk) #1;
            if (tx_valid_r !== 1'b1) begin
                errors = errors + 1;
                results;
            end
            chk("tx byte", {8'h00, tx_byte_r}, {8'h00, exp});
        end
    endtask
    task dx(input w, input [14:0] a, input [7:0] d);
        integer k;
        begin
            @(posedge ref_clk) #1 dma_req = 1;
            {dma_wr, dma_addr, dma_wdata} = {w, a, d};
            for (k = 0; k < 40 && dma_ack_r !== 1'b1; k = k + 1) @(posedge ref_clk);
            if (dma_ack_r !== 1'b1) begin
                errors = errors + 1;
                results;
            end
            q = {8'h00, dma_rdata_r};
            #1 dma_req = 0;
            dma_wdata = ~d;
        end
    endtask
    task t_start;
        begin
            hx(0, `SEL_RX_START, 0, 3, 0);
            chk("rx start", q, 16'h5340);
            chk("rx head", {1'b0, rx_head_r}, 16'h5340);
            hx(1, `SEL_RX_START, 0, 3, 16'h5401);
            hx(0, `SEL_RX_START, 0, 3, 0);
            chk("rx start", q, 16'h5400);
            hx(1, `SEL_RX_START, 0, 3, 16'h6000);
            hx(0, `SEL_RX_START, 0, 3, 0);
            chk("rx start", q, 16'h5400);
            receive_enable_bit = 1;
            hx(1, `SEL_RX_START, 0, 3, 16'h5FF0);
            hx(0, `SEL_RX_START, 0, 3, 0);
            chk("rx start", q, 16'h5400);
            receive_enable_bit = 0;
            hx(1, `SEL_RX_START, 0, 3, 16'h5FF0);
            $display("test start done");
        end
    endtask
    task t_gen;
        begin
            hx(1, `SEL_GEN_WR_PTR, 0, 3, 16'h5FEF);
            hx(1, `SEL_GEN_WINDOW, 0, 1, 16'hFFA1);
            hx(1, `SEL_GEN_WINDOW, 0, 2, 16'h00EE);
            hx(1, `SEL_GEN_WINDOW, 0, 1, 16'h00A2);
            hx(0, `SEL_GEN_WR_PTR, 0, 3, 0);
            chk("gen wr", q, 16'h0001);
            hx(1, `SEL_GEN_RD_PTR, 0, 3, 16'h5FEF);
            hx(0, `SEL_GEN_WINDOW, 0, 1, 0);
            chk("gen win", q, 16'h00A1);
            hx(0, `SEL_GEN_WINDOW, 0, 1, 0);
            chk("gen win", q, 16'h00A2);
            hx(0, `SEL_GEN_WR_PTR, 0, 3, 0);
            chk("gen wr", q, 16'h0001);
            $display("test general done");
        end
    endtask
    task t_rx;
        begin
            @(posedge ref_clk) #1 rx_restart = 1;
            @(posedge ref_clk) #1 rx_restart = 0;
            for (i = 0; i < 17; i = i + 1) begin
                rx_wr = 1;
                rx_byte = i;
                @(posedge ref_clk) #1;
            end
            rx_wr = 0;
            chk("rx head", {1'b0, rx_head_r}, 16'h5FF1);
            hx(1, `SEL_RX_RD_PTR, 0, 3, 16'h5FFF);
            hx(0, `SEL_RX_WINDOW, 0, 1, 0);
            chk("rx win", q, 16'h000F);
            hx(0, `SEL_RX_WINDOW, 0, 1, 0);
            chk("rx win", q, 16'h0010);
            $display("test receive done");
        end
    endtask
    task t_user;
        begin
            hx(1, `SEL_UA_START, 0, 3, 16'h0011);
            hx(1, `SEL_UA_END, 0, 3, 16'h0020);
            hx(0, `SEL_UA_START, 0, 3, 0);
            chk("ua start", q, 16'h0010);
            hx(0, `SEL_UA_END, 0, 3, 0);
            chk("ua end", q, 16'h0021);
            hx(1, `SEL_UA_WR_PTR, 0, 3, 16'h0021);
            hx(1, `SEL_UA_WINDOW, 0, 1, 16'h0033);
            hx(1, `SEL_UA_WINDOW, 0, 1, 16'h0044);
            hx(1, `SEL_UA_RD_PTR, 0, 3, 16'h0010);
            hx(0, `SEL_UA_WINDOW, 0, 1, 0);
            chk("ua win", q, 16'h0044);
            hx(1, `SEL_UA_RD_PTR, 0, 3, 16'h5FFF);
            hx(0, `SEL_UA_WINDOW, 0, 1, 0);
            hx(0, `SEL_UA_RD_PTR, 0, 3, 0);
            chk("ua rd", q, 16'h0000);
            $display("test user done");
        end
    endtask
    task t_direct;
        begin
            hx(1, `SEL_DIRECT, 15'h0030, 3, 16'hBEEF);
            hx(0, `SEL_DIRECT, 15'h0030, 3, 0);
            chk("direct", q, 16'hBEEF);
            serial_mode = 1;
            hx(1, `SEL_DIRECT, 15'h0030, 3, 16'h1234);
            hx(0, `SEL_DIRECT, 15'h0030, 3, 0);
            chk("serial", q, 16'h0000);
            serial_mode = 0;
            fork
                tx_chk(15'h0031, 8'hBE);
                hx(0, `SEL_DIRECT, 15'h0030, 3, 0);
            join
            chk("direct", q, 16'hBEEF);
            dx(1, 15'h0040, 8'h5A);
            tx_chk(15'h0040, 8'h5A);
            dx(0, 15'h0040, 8'h00);
            chk("dma rd", q, 16'h005A);
            $display("test direct done");
        end
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        #1 rstn = 1;
        t_start;
        t_gen;
        t_rx;
        t_user;
        t_direct;
        results;
    end
endmodule
